// ==== hbrss_device.sv ====
// Device end: bus request, address strobe, acknowledge wait, slave select
`timescale 1ns/10ps
// What this block does
// - Level style: request whenever grant inactive
// - Hold request low through whole transaction
// - Edge style: request only after pin high
// - Low grant makes device master
// - Arbiter keeps grant until request released
// - Drive strobe only as master
// - Polarity zero: latch enable falls, stays low
// - Polarity one: low pulse, rising captures
// - Host holds chip select low, stable
// - Port select picks data or address port
// - Memory acknowledges accepted or placed data
// - Slave ready follows strobe, drops after
// - Data stable at strobe rising edge
module hbrss_device
   import hbrss_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   hbrss_if.device bus,
   input wire logic dma_need_in,
   input wire logic bus_ctrl_style_bit_in,
   input wire logic strobe_polarity_bit_in,
   output logic master_out,
   output logic cycle_done_out,
   output logic addr_port_sel_out,
   output logic data_port_sel_out,
   output logic slave_ready_out
);

   // ==========================================
   // Master request and strobe sequencing
   hbrss_master_state_t st_reg, st_next;
   logic req_reg, req_next;
   logic req_prev_high_reg;
   logic oe_reg, oe_next;
   logic strb_reg, strb_next;
   logic [3:0] cnt_reg, cnt_next;
   logic ack_meta_reg, ack_sync_reg;
   logic style_reg, pol_reg;
   logic done_next;
   wire grant_inactive = bus.hold_grant;
   // Mode bits freeze once a transaction starts; a change in mid-cycle
   // would otherwise bend the strobe under a slave that is latching
   wire idle_now = (st_reg == HBRSS_IDLE);
   wire style_now = idle_now ? bus_ctrl_style_bit_in : style_reg;
   wire pol_now = idle_now ? strobe_polarity_bit_in : pol_reg;
   // Edge style needs the pin seen high first; level style does not
   wire style_level = (style_now == STYLE_LEVEL);
   wire may_request = grant_inactive & (style_level
      ? 1'b1
      : req_prev_high_reg);
   // Transition decodes for the sequencer
   wire start_req = dma_need_in & may_request;
   wire got_grant = ~bus.hold_grant;
   wire addr_done = (cnt_reg == ADDR_PHASE_CYC);
   wire ack_raw = ~bus.ready_line & oe_reg;
   wire ack_seen = ack_sync_reg;

   // ==========================================
   // Strobe levels
   // Driven strobe idles high; the enable drop hides it anyway
   wire strb_idle = 1'b1;
   wire pol_latch = (pol_now == POL_LATCH);
   wire strb_addr = pol_latch ? 1'b1 : 1'b0;
   // Latch form falls and stays low; pulse form rises
   wire strb_data = pol_latch
      ? 1'b0
      : 1'b1;

   // ==========================================
   // Next state
   // One transaction at a time; a need raised while busy waits for idle
   always_comb begin
      st_next = st_reg;
      req_next = req_reg;
      oe_next = oe_reg;
      strb_next = strb_reg;
      cnt_next = CNT_ZERO;
      done_next = 1'b0;
      case (st_reg)
         HBRSS_IDLE: if (start_req) begin
            st_next = HBRSS_REQ;
            req_next = 1'b1;
         end
         HBRSS_REQ: if (got_grant) begin
            st_next = HBRSS_ADDR;
            oe_next = 1'b1;
            strb_next = strb_addr;
            cnt_next = CNT_ONE;
         end
         HBRSS_ADDR: begin
            cnt_next = cnt_reg + CNT_ONE;
            if (addr_done) begin
               st_next = HBRSS_DATA;
               strb_next = strb_data;
            end
         end
         HBRSS_DATA: if (ack_seen) begin
            st_next = HBRSS_DONE;
            done_next = 1'b1;
         end
         HBRSS_DONE: begin
            st_next = HBRSS_IDLE;
            req_next = 1'b0;
            oe_next = 1'b0;
            strb_next = strb_idle;
         end
         default: st_next = HBRSS_IDLE;
      endcase
   end

   // ==========================================
   // Sequencer registers
   // Counter falls back to zero outside the address phase by default
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_reg <= HBRSS_IDLE;
         req_reg <= 1'b0;
         oe_reg <= 1'b0;
         strb_reg <= 1'b1;
         cnt_reg <= CNT_ZERO;
      end else begin
         st_reg <= st_next;
         req_reg <= req_next;
         oe_reg <= oe_next;
         strb_reg <= strb_next;
         cnt_reg <= cnt_next;
      end
   end

   // ==========================================
   // Mode bits and request pin history
   // Released request floats high, so its history starts high too
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         style_reg <= STYLE_LEVEL;
         pol_reg <= POL_LATCH;
         req_prev_high_reg <= 1'b1;
      end else begin
         style_reg <= style_now;
         pol_reg <= pol_now;
         req_prev_high_reg <= bus.req_line;
      end
   end

   // ==========================================
   // Acknowledge synchroniser
   // Acknowledge is asynchronous: two stages before use
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ack_meta_reg <= 1'b0;
         ack_sync_reg <= 1'b0;
      end else begin
         ack_meta_reg <= ack_raw;
         ack_sync_reg <= ack_meta_reg;
      end
   end

   // ==========================================
   // Status outputs and pins
   // Master flag and strobe enable change on the same edge
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         master_out <= 1'b0;
         cycle_done_out <= 1'b0;
      end else begin
         master_out <= oe_next;
         cycle_done_out <= done_next;
      end
   end
   assign bus.req_oe = req_reg;
   assign bus.strobe_oe = oe_reg;
   assign bus.strobe_o = strb_reg;

   // ==========================================
   // Register slave select and ready
   logic rdy_reg;
   wire selected = ~bus.chip_sel_n;
   // Ready is refused while master so the shared line keeps one meaning
   wire rdy_next = selected & ~bus.data_strobe & ~oe_reg;
   wire addr_port_hit = selected & (bus.port_sel == PORT_ADDR);
   wire data_port_hit = selected & (bus.port_sel == PORT_DATA);
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdy_reg <= 1'b0;
         slave_ready_out <= 1'b0;
      end else begin
         rdy_reg <= rdy_next;
         slave_ready_out <= rdy_next;
      end
   end

   // Port decode is registered so the outputs come from flops
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         addr_port_sel_out <= 1'b0;
         data_port_sel_out <= 1'b0;
      end else begin
         addr_port_sel_out <= addr_port_hit;
         data_port_sel_out <= data_port_hit;
      end
   end
   assign bus.dev_ready_oe = rdy_reg;
endmodule

// ==== hbrss_pkg.sv ====
// Package of shared constants and types for the host bus request and select block
package hbrss_pkg;
   // Bus-control style encodings
   localparam logic STYLE_LEVEL = 1'b0;
   localparam logic STYLE_EDGE = 1'b1;
   // Strobe polarity encodings
   localparam logic POL_LATCH = 1'b0;
   localparam logic POL_PULSE = 1'b1;
   // Port select encodings
   localparam logic PORT_DATA = 1'b0;
   localparam logic PORT_ADDR = 1'b1;
   // Address phase length in system clocks
   localparam int ADDR_PHASE_NS = 40;
   localparam int CLK_PERIOD_NS = 20;
   localparam int ADDR_PHASE_CYC_INT =
      (ADDR_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] ADDR_PHASE_CYC = 4'(ADDR_PHASE_CYC_INT);
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   // Host side ready delay in clocks
   localparam logic [3:0] HOST_ACK_DELAY = 4'h2;
   typedef enum logic [2:0] {
      HBRSS_IDLE, HBRSS_REQ, HBRSS_ADDR, HBRSS_DATA, HBRSS_DONE
   } hbrss_master_state_t;
endpackage

// ==== hbrss_if.sv ====
// Interface joining the device end and the host side end of the bus
`timescale 1ns/10ps
interface hbrss_if;
   // Open-drain request: low when device enables its pull-down
   logic req_oe;
   logic req_line;
   logic hold_grant;
   // Three-state strobe
   logic strobe_o;
   logic strobe_oe;
   logic strobe_line;
   logic data_strobe;
   logic chip_sel_n;
   logic port_sel;
   // Open-drain ready: device pulls low as slave, memory acks as master
   logic dev_ready_oe;
   logic mem_ready_oe;
   logic ready_line;
   assign req_line = req_oe ? 1'b0 : 1'b1;
   assign strobe_line = strobe_oe ? strobe_o : 1'b1;
   assign ready_line = (dev_ready_oe | mem_ready_oe) ? 1'b0 : 1'b1;
   modport device (
      output req_oe, strobe_o, strobe_oe, dev_ready_oe,
      input req_line, hold_grant, chip_sel_n, port_sel, data_strobe,
      input ready_line
   );
   modport host (
      output hold_grant, chip_sel_n, port_sel, data_strobe, mem_ready_oe,
      input req_line, strobe_line, ready_line, strobe_oe
   );
endinterface

// ==== hbrss_host.sv ====
// Host side end: arbiter, memory acknowledge and register slave access
`timescale 1ns/10ps
module hbrss_host
   import hbrss_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   hbrss_if.host bus,
   input wire logic slave_go_in,
   input wire logic slave_port_in,
   output logic slave_done_out,
   output logic granted_out
);
   // ==========================================
   // Arbiter and memory acknowledge
   logic grant_reg, grant_next;
   logic ack_reg, ack_next;
   logic [3:0] ack_cnt_reg, ack_cnt_next;
   wire req_low = ~bus.req_line;
   // Grant stays low until the request has gone high
   assign grant_next = req_low ? 1'b0 : 1'b1;
   // Data phase starts when the strobe leaves its first driven level, so
   // the memory works for either strobe polarity
   logic oe_seen_reg, first_lvl_reg;
   wire strobe_on = bus.strobe_oe & oe_seen_reg;
   wire strobe_moved = bus.strobe_line != first_lvl_reg;
   wire first_lvl_next = (bus.strobe_oe & ~oe_seen_reg) ?
      bus.strobe_line : first_lvl_reg;
   wire in_data = ~grant_reg & req_low & strobe_on & strobe_moved;
   assign ack_cnt_next = in_data ? ((ack_cnt_reg == HOST_ACK_DELAY) ?
      ack_cnt_reg : ack_cnt_reg + CNT_ONE) : CNT_ZERO;
   assign ack_next = in_data & (ack_cnt_reg == HOST_ACK_DELAY);
   // ==========================================
   // Register slave access
   typedef enum logic [1:0] {HS_IDLE, HS_SEL, HS_STRB, HS_END} hbrss_hs_t;
   hbrss_hs_t hs_reg, hs_next;
   logic cs_reg, cs_next, ds_reg, ds_next, ps_reg, ps_next, done_next;
   wire dev_rdy = ~bus.ready_line & grant_reg;
   always_comb begin
      hs_next = hs_reg;
      cs_next = cs_reg;
      ds_next = ds_reg;
      ps_next = ps_reg;
      done_next = 1'b0;
      case (hs_reg)
         HS_IDLE: if (slave_go_in & grant_reg) begin
            hs_next = HS_SEL;
            cs_next = 1'b0;
            ps_next = slave_port_in;
         end
         HS_SEL: begin
            hs_next = HS_STRB;
            ds_next = 1'b0;
         end
         HS_STRB: if (dev_rdy) begin
            hs_next = HS_END;
            ds_next = 1'b1;
         end
         HS_END: begin
            hs_next = HS_IDLE;
            cs_next = 1'b1;
            done_next = 1'b1;
         end
         default: hs_next = HS_IDLE;
      endcase
   end
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         grant_reg <= 1'b1;
         ack_reg <= 1'b0;
         ack_cnt_reg <= CNT_ZERO;
         oe_seen_reg <= 1'b0;
         first_lvl_reg <= 1'b1;
         hs_reg <= HS_IDLE;
         cs_reg <= 1'b1;
         ds_reg <= 1'b1;
         ps_reg <= PORT_DATA;
         slave_done_out <= 1'b0;
         granted_out <= 1'b0;
      end else begin
         grant_reg <= grant_next;
         ack_reg <= ack_next;
         ack_cnt_reg <= ack_cnt_next;
         oe_seen_reg <= bus.strobe_oe;
         first_lvl_reg <= first_lvl_next;
         hs_reg <= hs_next;
         cs_reg <= cs_next;
         ds_reg <= ds_next;
         ps_reg <= ps_next;
         slave_done_out <= done_next;
         granted_out <= ~grant_next;
      end
   end
   assign bus.hold_grant = grant_reg;
   assign bus.mem_ready_oe = ack_reg;
   assign bus.chip_sel_n = cs_reg;
   assign bus.data_strobe = ds_reg;
   assign bus.port_sel = ps_reg;
endmodule

// ==== hbrss_chk.sv ====
// Concurrent checks on the wires between the two ends
`timescale 1ns/10ps
module hbrss_chk (
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic req_oe,
   input wire logic hold_grant,
   input wire logic strobe_o,
   input wire logic strobe_oe,
   input wire logic data_strobe,
   input wire logic chip_sel_n,
   input wire logic dev_ready_oe,
   input wire logic mem_ready_oe
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   // ==================================================
   // Address phase: strobe level holds, then flips
   sequence addr_phase_s;
      ##[1:3] $changed(strobe_o);
   endsequence
   sequence slave_ask_s;
      !chip_sel_n && !data_strobe && !req_oe;
   endsequence
   a_req_grant_idle: assert property ($rose(req_oe) |-> hold_grant)
      else $error("request raised while grant low");
   a_req_held_cycle: assert property (strobe_oe |-> req_oe)
      else $error("request dropped during transaction");
   a_master_on_grant: assert property ($rose(strobe_oe) |-> !$past(hold_grant))
      else $error("strobe driven before grant");
   a_grant_kept: assert property ($rose(hold_grant) |-> !req_oe)
      else $error("grant withdrawn while request held");
   a_strobe_master: assert property (strobe_oe |-> !hold_grant)
      else $error("strobe driven while not master");
   a_strobe_shape: assert property ($rose(strobe_oe) |-> addr_phase_s)
      else $error("address phase strobe did not change");
   a_ready_answer: assert property (slave_ask_s |=> dev_ready_oe)
      else $error("slave ready missing");
   a_ready_drop: assert property
      (dev_ready_oe && data_strobe |-> ##[1:2] !dev_ready_oe)
      else $error("slave ready not released");
   a_ack_ends_cycle: assert property ($rose(mem_ready_oe) |-> ##[1:8] !req_oe)
      else $error("master cycle not ended after ack");
endmodule

// ==== hbrss_test.sv ====
// Testbench joining both ends through the bus interface
`timescale 1ns/10ps
module hbrss_test;
   import hbrss_pkg::*;
   logic core_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic need = 1'b0;
   logic style = 1'b0;
   logic pol = 1'b0;
   logic go = 1'b0;
   logic port = 1'b0;
   logic master, cdone, aport, dport, sready, sdone, granted;
   int n_mismatch = 0;
   int cmp_count = 0;
   hbrss_if bus();
   hbrss_device i_hbrss_device (.core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in), .bus(bus.device), .dma_need_in(need),
      .bus_ctrl_style_bit_in(style), .strobe_polarity_bit_in(pol),
      .master_out(master), .cycle_done_out(cdone),
      .addr_port_sel_out(aport), .data_port_sel_out(dport),
      .slave_ready_out(sready));
   hbrss_host i_hbrss_host (.core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in), .bus(bus.host), .slave_go_in(go),
      .slave_port_in(port), .slave_done_out(sdone),
      .granted_out(granted));
   hbrss_chk i_hbrss_chk (.core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in), .req_oe(bus.req_oe),
      .hold_grant(bus.hold_grant), .strobe_o(bus.strobe_o),
      .strobe_oe(bus.strobe_oe), .data_strobe(bus.data_strobe),
      .chip_sel_n(bus.chip_sel_n), .dev_ready_oe(bus.dev_ready_oe),
      .mem_ready_oe(bus.mem_ready_oe));
   always #10 core_clk_in = ~core_clk_in;
   // ==================================================
   // Compare and verdict
   task automatic check(input logic seen, input logic exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t saw %b want %b", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ==================================================
   // One DMA cycle as master, sampled at falling edges
   task automatic master_cycle(input logic s, input logic p);
      @(posedge core_clk_in);
      style <= s;
      pol <= p;
      need <= 1'b1;
      for (int i = 0; i < 20 && bus.strobe_oe !== 1'b1; i++)
         @(negedge core_clk_in);
      check(master, 1'b1);
      check(granted, 1'b1);
      check(bus.strobe_line, ~p);
      for (int i = 0; i < 5 && bus.strobe_line === ~p; i++)
         @(negedge core_clk_in);
      check(bus.strobe_line, p);
      check(bus.req_line, 1'b0);
      for (int i = 0; i < 20 && cdone !== 1'b1; i++)
         @(negedge core_clk_in);
      check(cdone, 1'b1);
      check(bus.req_line, 1'b0);
      @(posedge core_clk_in);
      need <= 1'b0;
      repeat (4) @(negedge core_clk_in);
      check(bus.req_line, 1'b1);
      check(bus.strobe_line, 1'b1);
      check(granted, 1'b0);
   endtask
   // One register port access by the host
   task automatic slave_access(input logic p);
      @(posedge core_clk_in);
      port <= p;
      go <= 1'b1;
      @(posedge core_clk_in);
      go <= 1'b0;
      for (int i = 0; i < 20 && sready !== 1'b1; i++)
         @(negedge core_clk_in);
      check(aport, p);
      check(dport, ~p);
      check(bus.ready_line, 1'b0);
      for (int i = 0; i < 20 && sdone !== 1'b1; i++)
         @(negedge core_clk_in);
      check(sdone, 1'b1);
      check(bus.ready_line, 1'b1);
   endtask
   initial begin
      repeat (8) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      // Every style and polarity pairing
      for (int k = 0; k < 4; k++)
         master_cycle(k[0], k[1]);
      slave_access(PORT_ADDR);
      slave_access(PORT_DATA);
      end_sim();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      #40000;
      n_mismatch++;
      end_sim();
   end
endmodule
